// ### opt_cfg_pkg.sv
// Constants shared by the option byte loader, decoder and top level.
// Assumes a byte-wide flash read port and a 32-bit Wishbone register bus.
package opt_cfg_pkg;
	////////////////////////////////////////////////////////////////////////
	// Flash locations of the two option bytes
	localparam int FLASH_AW = 20;
	localparam logic [19:0] FLASH_WD_ADDR = 20'h000C0;
	localparam logic [19:0] FLASH_DC_ADDR = 20'h000C1;
	localparam logic [19:0] FLASH_SWAP_OFS = 20'h02000;
	////////////////////////////////////////////////////////////////////////
	// Watchdog option byte fields
	localparam int WD_IRQEN_BIT = 7;
	localparam int WD_WIN_LSB = 5;
	localparam int WD_AUTO_BIT = 4;
	localparam int WD_OVF_LSB = 1;
	localparam int WD_STBY_BIT = 0;
	////////////////////////////////////////////////////////////////////////
	// Detector and clock monitor option byte fields
	localparam int DC_HIGH_LSB = 5;
	localparam int DC_CMDIS_BIT = 4;
	localparam int DC_LOW_LSB = 2;
	localparam int DC_MODE_LSB = 0;
	////////////////////////////////////////////////////////////////////////
	// Register indexes; byte address is four times the index
	localparam int BUS_AW = 12;
	localparam logic [9:0] IDX_WD = 10'h0C0;
	localparam logic [9:0] IDX_DC = 10'h0C1;
	localparam logic [9:0] IDX_STAT = 10'h0C4;
	localparam logic [9:0] IDX_MASK = 10'h0C5;
	localparam logic [9:0] IDX_CTRL = 10'h0C6;
	localparam logic [9:0] IDX_DEC = 10'h0C7;
	////////////////////////////////////////////////////////////////////////
	// Status, mask and control layout
	localparam int STAT_W = 4;
	localparam int ST_LOADED = 0;
	localparam int ST_WIN_BAD = 1;
	localparam int ST_DET_BAD = 2;
	localparam int ST_INTERVAL = 3;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam int CTRL_IAC_BIT = 0;
	localparam logic CTRL_IAC_RST = 1'b0;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {WIN_BAD = 2'b00, WIN_50 = 2'b01, WIN_75 = 2'b10,
		WIN_100 = 2'b11} window_e;
	typedef enum logic [1:0] {MODE_BAD = 2'b00, MODE_IRQ = 2'b01, MODE_IRQ_RST = 2'b10,
		MODE_RST = 2'b11} mode_e;
	typedef enum logic [2:0] {LVL0 = 3'b000, LVL1 = 3'b001, LVL2 = 3'b010, LVL3 = 3'b011,
		LVL4 = 3'b100, LVL5 = 3'b101, LVL_OFF = 3'b110, LVL_BAD = 3'b111} level_e;
endpackage

// ### opt_if.sv
// Carries fetched option bytes and their decoded fields between modules.
// Assumes one clock domain; decoded fields are combinational.
`timescale 1ns/100ps
interface opt_if;
	logic [7:0] wdByte;
	logic [7:0] dcByte;
	logic loaded;
	opt_cfg_pkg::window_e window;
	opt_cfg_pkg::mode_e mode;
	opt_cfg_pkg::level_e level;
	logic windowBad;
	logic detBad;
	modport fetcher (output wdByte, dcByte, loaded);
	modport decoder (input wdByte, dcByte, output window, mode, level, windowBad, detBad);
	modport consumer (input wdByte, dcByte, loaded, window, mode, level, windowBad, detBad);
endinterface

// ### option_fetch.sv
// Reads the two option bytes from flash once after reset release.
// Assumes the flash answers on clk; bootSwap is stable from same-clock logic.
`timescale 1ns/100ps
module option_fetch (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic clkEn,
	// Flash read port
	output logic flashReq,
	output logic [19:0] flashAddr,
	input wire logic flashAck,
	input wire logic [7:0] flashData,
	input wire logic bootSwap,
	// Fetched bytes
	opt_if.fetcher opt
);
	typedef enum logic [1:0] {FS_START = 2'b00, FS_WD = 2'b01, FS_DC = 2'b10,
		FS_DONE = 2'b11} fetch_e;
	typedef struct packed {
		fetch_e st;
		logic [19:0] base;
		logic [7:0] wd;
		logic [7:0] dc;
	} fetch_s;
	fetch_s q_r, q_nxt;

	always_comb begin
		q_nxt = q_r;
		case (q_r.st)
			// Strap caught one cycle after release
			FS_START: begin
				q_nxt.base = bootSwap ? opt_cfg_pkg::FLASH_SWAP_OFS : 20'h00000;
				q_nxt.st = FS_WD;
			end
			FS_WD: if (flashAck) begin
				q_nxt.wd = flashData;
				q_nxt.st = FS_DC;
			end
			FS_DC: if (flashAck) begin
				q_nxt.dc = flashData;
				q_nxt.st = FS_DONE;
			end
			// Held until the next reset
			FS_DONE: q_nxt = q_r;
			default: q_nxt.st = FS_START;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q_r <= '{st: FS_START, base: 20'h00000, wd: 8'h00, dc: 8'h00};
		end else if (clkEn) begin
			q_r <= q_nxt;
		end
	end

	assign flashReq = (q_r.st == FS_WD) || (q_r.st == FS_DC);
	assign flashAddr = q_r.base + ((q_r.st == FS_DC) ? opt_cfg_pkg::FLASH_DC_ADDR :
		opt_cfg_pkg::FLASH_WD_ADDR);
	assign opt.wdByte = q_r.wd;
	assign opt.dcByte = q_r.dc;
	assign opt.loaded = (q_r.st == FS_DONE);
endmodule

// ### option_decode.sv
// Turns the two raw option bytes into watchdog and detector settings.
// Purely combinational; assumes bytes held stable by the fetch logic.
`timescale 1ns/100ps
module option_decode (
	// Raw bytes in, fields out
	opt_if.decoder opt
);
	function automatic opt_cfg_pkg::level_e levelOf(input logic [2:0] hi, input logic [1:0] lo);
		levelOf = opt_cfg_pkg::LVL_BAD;
		if (hi[2]) begin
			levelOf = opt_cfg_pkg::LVL_OFF;
		end else begin
			case ({hi[1:0], lo})
				4'b0001: levelOf = opt_cfg_pkg::LVL4;
				4'b0100: levelOf = opt_cfg_pkg::LVL2;
				4'b1000: levelOf = opt_cfg_pkg::LVL1;
				4'b1100: levelOf = opt_cfg_pkg::LVL0;
				4'b1101: levelOf = opt_cfg_pkg::LVL3;
				4'b1111: levelOf = opt_cfg_pkg::LVL5;
				default: levelOf = opt_cfg_pkg::LVL_BAD;
			endcase
		end
	endfunction

	logic [1:0] winCode;
	logic [1:0] modeCode;
	opt_cfg_pkg::level_e lvl;

	always_comb begin
		winCode = opt.wdByte[opt_cfg_pkg::WD_WIN_LSB +: 2];
		modeCode = opt.dcByte[opt_cfg_pkg::DC_MODE_LSB +: 2];
		lvl = levelOf(opt.dcByte[opt_cfg_pkg::DC_HIGH_LSB +: 3],
			opt.dcByte[opt_cfg_pkg::DC_LOW_LSB +: 2]);
		opt.window = opt_cfg_pkg::window_e'(winCode);
		opt.windowBad = (winCode == 2'b00);
		opt.mode = opt_cfg_pkg::mode_e'(modeCode);
		// Combined mode levels are not decoded here
		opt.level = (opt.mode == opt_cfg_pkg::MODE_IRQ_RST && lvl != opt_cfg_pkg::LVL_OFF) ?
			opt_cfg_pkg::LVL_BAD : lvl;
		// Level 5 with interrupt only is flagged as a bad image
		opt.detBad = (opt.mode == opt_cfg_pkg::MODE_BAD) ||
			(opt.level == opt_cfg_pkg::LVL_BAD) ||
			(opt.mode == opt_cfg_pkg::MODE_IRQ && opt.level == opt_cfg_pkg::LVL5);
	end
endmodule

// ### option_byte_config_decoder.sv
// Top level: fetches the option bytes after reset, drives the watchdog,
// detector and clock monitor settings, and exposes them on Wishbone.
// Assumes flash port, watchdog tick and bus all run on clk.
//
// How it works
// - Standby count off forces the full 100% window, whatever window code.
// - Auto-start set keeps illegal access detection on regardless of control bit.
// - Interval interrupt and its flag only when the option enable bit is 1.
// - Second byte: high level 7:5, monitor disable 4, low level 3:2, mode 1:0.
// - Clock monitor runs when its disable bit is 0, stopped when 1.
// - Mode 01 interrupt, 10 interrupt plus reset, 11 reset, 00 forbidden.
// - Level select pairs map to detection levels 0 to 5 outside mode 10; others forbidden.
// - High level select 100 to 111 keeps the detector stopped.
// - Option bytes are read from flash automatically after power-on reset.
// - Window code 01 gives 50%, 10 gives 75%, 11 gives 100%.
// - Standby count off halts the counter in low-power modes.
`timescale 1ns/100ps
module option_byte_config_decoder (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic clkEn,
	// Flash read port
	output logic flashReq,
	output logic [19:0] flashAddr,
	input wire logic flashAck,
	input wire logic [7:0] flashData,
	input wire logic bootSwap,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Watchdog side
	input wire logic wdtIntervalTick,
	input wire logic lowPowerMode,
	output logic wdtCounterRun,
	output logic [1:0] windowSelect,
	output logic [2:0] overflowTimeSelect,
	output logic intervalIrqReq,
	output logic intervalIrqFlag,
	output logic illegalAccessDetectEnable,
	// Detector and clock monitor
	output logic [1:0] detectorMode,
	output logic [2:0] detectLevel,
	output logic detectorRun,
	output logic clockMonitorRun,
	// Status
	output logic configValid,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// Submodules
	opt_if opt ();

	option_fetch u_fetch (
		.clk(clk),
		.srst(srst),
		.clkEn(clkEn),
		.flashReq(flashReq),
		.flashAddr(flashAddr),
		.flashAck(flashAck),
		.flashData(flashData),
		.bootSwap(bootSwap),
		.opt(opt.fetcher)
	);

	option_decode u_decode (
		.opt(opt.decoder)
	);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic ack;
		logic [31:0] rdData;
		logic [3:0] status;
		logic [3:0] mask;
		logic iaCtrl;
		logic loadedSeen;
		logic intPulse;
		logic cntRun;
		logic [1:0] window;
		logic [2:0] ovf;
		logic iaDet;
		logic [1:0] mode;
		logic [2:0] level;
		logic detRun;
		logic cmRun;
		logic valid;
		logic irq;
	} top_s;
	top_s q_r, q_nxt;

	localparam top_s TOP_RST = '{
		ack: 1'b0,
		rdData: 32'h0000_0000,
		status: 4'h0,
		mask: opt_cfg_pkg::MASK_RST,
		iaCtrl: opt_cfg_pkg::CTRL_IAC_RST,
		loadedSeen: 1'b0,
		intPulse: 1'b0,
		cntRun: 1'b0,
		window: 2'h3,
		ovf: 3'h0,
		iaDet: 1'b0,
		mode: 2'h0,
		level: 3'h6,
		detRun: 1'b0,
		cmRun: 1'b0,
		valid: 1'b0,
		irq: 1'b0
	};

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
		hit = (adr[11:2] == idx);
	endfunction

	logic access;
	logic wrCycle;
	logic rdCycle;
	logic newLoad;
	logic intervalEn;
	logic standbyEn;
	logic autoStart;
	logic [3:0] setBits;
	logic [31:0] decWord;
	logic [31:0] rdMux;

	always_comb begin
		// Act on the cycle the ack is issued; master holds the request until then
		access = wb_cyc_i && wb_stb_i && !q_r.ack;
		wrCycle = access && wb_we_i && wb_sel_i[0];
		rdCycle = access && !wb_we_i;
		newLoad = opt.loaded && !q_r.loadedSeen;
		intervalEn = opt.wdByte[opt_cfg_pkg::WD_IRQEN_BIT];
		standbyEn = opt.wdByte[opt_cfg_pkg::WD_STBY_BIT];
		autoStart = opt.wdByte[opt_cfg_pkg::WD_AUTO_BIT];
		setBits = 4'h0;
		setBits[opt_cfg_pkg::ST_LOADED] = newLoad;
		setBits[opt_cfg_pkg::ST_WIN_BAD] = newLoad && opt.windowBad;
		setBits[opt_cfg_pkg::ST_DET_BAD] = newLoad && opt.detBad;
		// Tick ignored unless the option byte enables it
		setBits[opt_cfg_pkg::ST_INTERVAL] = opt.loaded && intervalEn && wdtIntervalTick;
		decWord = 32'h0000_0000;
		decWord[1:0] = q_r.window;
		decWord[4:2] = q_r.level;
		decWord[6:5] = q_r.mode;
		decWord[7] = q_r.cntRun;
		decWord[8] = q_r.detRun;
		decWord[9] = q_r.cmRun;
		decWord[10] = q_r.iaDet;
		decWord[11] = q_r.valid;
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read as zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (hit(wb_adr_i, opt_cfg_pkg::IDX_WD)) begin
			rdMux[7:0] = opt.wdByte;
		end else if (hit(wb_adr_i, opt_cfg_pkg::IDX_DC)) begin
			rdMux[7:0] = opt.dcByte;
		end else if (hit(wb_adr_i, opt_cfg_pkg::IDX_STAT)) begin
			rdMux[3:0] = q_r.status;
		end else if (hit(wb_adr_i, opt_cfg_pkg::IDX_MASK)) begin
			rdMux[3:0] = q_r.mask;
		end else if (hit(wb_adr_i, opt_cfg_pkg::IDX_CTRL)) begin
			rdMux[opt_cfg_pkg::CTRL_IAC_BIT] = q_r.iaCtrl;
		end else if (hit(wb_adr_i, opt_cfg_pkg::IDX_DEC)) begin
			rdMux = decWord;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		q_nxt = q_r;
		q_nxt.ack = access;
		if (rdCycle) begin
			q_nxt.rdData = rdMux;
		end
		q_nxt.loadedSeen = opt.loaded;
		q_nxt.intPulse = setBits[opt_cfg_pkg::ST_INTERVAL];

		// Read clears status; a coincident set survives
		if (rdCycle && hit(wb_adr_i, opt_cfg_pkg::IDX_STAT)) begin
			q_nxt.status = setBits;
		end else begin
			q_nxt.status = q_r.status | setBits;
		end

		// Option byte addresses are read-only
		if (wrCycle && hit(wb_adr_i, opt_cfg_pkg::IDX_MASK)) begin
			q_nxt.mask = wb_dat_i[3:0];
		end
		if (wrCycle && hit(wb_adr_i, opt_cfg_pkg::IDX_CTRL)) begin
			q_nxt.iaCtrl = wb_dat_i[opt_cfg_pkg::CTRL_IAC_BIT];
		end

		// Settings follow the fetched bytes, frozen until reset; cntRun also tracks lowPowerMode and iaDet the control bit
		q_nxt.valid = opt.loaded;
		if (opt.loaded) begin
			// Window choice only honoured with standby counting on
			q_nxt.window = standbyEn ? opt.window : opt_cfg_pkg::WIN_100;
			q_nxt.ovf = opt.wdByte[opt_cfg_pkg::WD_OVF_LSB +: 3];
			// Counter halts in low-power modes without standby counting
			q_nxt.cntRun = autoStart && (standbyEn || !lowPowerMode);
			q_nxt.iaDet = autoStart || q_r.iaCtrl;
			q_nxt.mode = opt.mode;
			q_nxt.level = opt.level;
			// A bad image keeps the detector off rather than guess a level
			q_nxt.detRun = (opt.level != opt_cfg_pkg::LVL_OFF) && !opt.detBad;
			q_nxt.cmRun = !opt.dcByte[opt_cfg_pkg::DC_CMDIS_BIT];
		end else begin
			q_nxt.iaDet = q_r.iaCtrl;
		end

		q_nxt.irq = |(q_nxt.status & q_nxt.mask);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q_r <= TOP_RST;
		end else if (clkEn) begin
			q_r <= q_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_ack_o = q_r.ack;
	assign wb_dat_o = q_r.rdData;
	assign wdtCounterRun = q_r.cntRun;
	assign windowSelect = q_r.window;
	assign overflowTimeSelect = q_r.ovf;
	assign intervalIrqReq = q_r.intPulse;
	assign intervalIrqFlag = q_r.status[opt_cfg_pkg::ST_INTERVAL];
	assign illegalAccessDetectEnable = q_r.iaDet;
	assign detectorMode = q_r.mode;
	assign detectLevel = q_r.level;
	assign detectorRun = q_r.detRun;
	assign clockMonitorRun = q_r.cmRun;
	assign configValid = q_r.valid;
	assign irq = q_r.irq;
endmodule

// ### opt_flash_model.sv
// Flash option byte area: answers byte reads after a chosen latency.
// Assumes the reader holds request and address until it sees the ack.
`timescale 1ns/100ps
module opt_flash_model (
	// Clock
	input wire logic clk,
	// Read port
	input wire logic flashReq,
	input wire logic [19:0] flashAddr,
	output logic flashAck,
	output logic [7:0] flashData,
	// Contents and pacing
	input wire logic [7:0] wdByte,
	input wire logic [7:0] dcByte,
	input wire logic swap,
	input wire logic [1:0] lat
);
	int cnt = 0;
	logic [7:0] word;
	initial begin
		flashAck = 1'b0;
		flashData = 8'h00;
	end
	// Only the copy picked by swap holds the bytes; any other address gets garbage
	always_comb begin
		word = ~wdByte;
		if (flashAddr == (swap ? 20'h020C0 : 20'h000C0)) word = wdByte;
		if (flashAddr == (swap ? 20'h020C1 : 20'h000C1)) word = dcByte;
	end
	// Data line inverts each cycle outside the ack cycle, so a stale byte shows every other cycle
	always @(posedge clk) begin
		flashAck <= 1'b0;
		flashData <= ~flashData;
		if (flashReq && !flashAck) begin
			if (cnt >= lat) begin
				flashAck <= 1'b1;
				flashData <= word;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// ### option_byte_config_decoder_checker.sv
// Assertions on the option byte decoder top-level ports.
// Assumes a single clock; shadows the bytes as they cross the flash port.
`timescale 1ns/100ps
module option_byte_config_decoder_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic clkEn,
	// Flash and bus
	input wire logic flashReq,
	input wire logic [19:0] flashAddr,
	input wire logic flashAck,
	input wire logic [7:0] flashData,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Watched tick input and outputs
	input wire logic wdtIntervalTick,
	input wire logic [1:0] windowSelect,
	input wire logic intervalIrqReq,
	input wire logic illegalAccessDetectEnable,
	input wire logic [1:0] detectorMode,
	input wire logic [2:0] detectLevel,
	input wire logic detectorRun,
	input wire logic clockMonitorRun,
	input wire logic configValid
);
	logic [7:0] wdCap_r;
	logic [7:0] dcCap_r;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk) begin
		if (srst) begin
			wdCap_r <= 8'h00;
			dcCap_r <= 8'h00;
		end else if (clkEn && flashReq && flashAck) begin
			if (flashAddr[0]) dcCap_r <= flashData;
			else wdCap_r <= flashData;
		end
	end
	////////////////////////////////////////////////////////////////////////
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse after request");
	fetch_start_a: assert property ($fell(srst) |-> ##[1:2] (flashReq && flashAddr[7:0] == 8'hC0))
		else $error("first flash read missing");
	fetch_done_a: assert property (clkEn && flashReq && flashAck && flashAddr[0] |-> ##2 configValid)
		else $error("config not valid after second byte");
	win_force_a: assert property (configValid |-> windowSelect == (wdCap_r[0] ? wdCap_r[6:5] : 2'b11))
		else $error("window select wrong");
	ia_auto_a: assert property (configValid && wdCap_r[4] |-> illegalAccessDetectEnable)
		else $error("illegal access detect off with autostart");
	irq_gate_a: assert property (intervalIrqReq |-> wdCap_r[7] && $past(wdtIntervalTick))
		else $error("interval request without enabled tick");
	irq_cause_a: assert property (configValid && clkEn && wdtIntervalTick && wdCap_r[7] |=> intervalIrqReq)
		else $error("interval request missing");
	cm_run_a: assert property (configValid |-> clockMonitorRun == !dcCap_r[4])
		else $error("clock monitor state wrong");
	det_mode_a: assert property (configValid |-> detectorMode == dcCap_r[1:0])
		else $error("detector mode wrong");
	det_stop_a: assert property (configValid && dcCap_r[7] |-> detectLevel == 3'h6 && !detectorRun)
		else $error("detector not stopped");
	cfg_hold_a: assert property (configValid && $past(configValid) |->
		$stable(windowSelect) && $stable(detectLevel) && $stable(detectorMode))
		else $error("decoded options changed");
	cover property (configValid && detectorRun);
	cover property (intervalIrqReq);
	cover property (wb_ack_o && configValid);
endmodule
bind option_byte_config_decoder option_byte_config_decoder_checker chk (.clk, .srst, .clkEn, .flashReq,
	.flashAddr, .flashAck, .flashData, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wdtIntervalTick,
	.windowSelect, .intervalIrqReq, .illegalAccessDetectEnable, .detectorMode, .detectLevel,
	.detectorRun, .clockMonitorRun, .configValid);

// ### option_byte_config_decoder_tb_top.sv
// Self-checking bench for the option byte decoder.
// Assumes the flash model answers reads; bus cycles are classic Wishbone.
`timescale 1ns/100ps
module option_byte_config_decoder_tb_top;
	logic clk, srst = 1'b1, clkEn = 1'b1, bootSwap = 1'b0, wdtIntervalTick = 1'b0, lowPowerMode = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, flashReq, flashAck;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [19:0] flashAddr;
	logic [7:0] flashData, wdB = 8'h00, dcB = 8'h00;
	logic [1:0] windowSelect, detectorMode, lat = 2'h0;
	logic [2:0] overflowTimeSelect, detectLevel;
	logic wdtCounterRun, intervalIrqReq, intervalIrqFlag, illegalAccessDetectEnable;
	logic detectorRun, clockMonitorRun, configValid, irq;
	int n_mismatch = 0;
	int n_compared = 0;
	option_byte_config_decoder option_byte_config_decoder_inst (.clk, .srst, .clkEn, .flashReq,
		.flashAddr, .flashAck, .flashData, .bootSwap, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wdtIntervalTick, .lowPowerMode, .wdtCounterRun,
		.windowSelect, .overflowTimeSelect, .intervalIrqReq, .intervalIrqFlag,
		.illegalAccessDetectEnable, .detectorMode, .detectLevel, .detectorRun, .clockMonitorRun,
		.configValid, .irq);
	opt_flash_model opt_flash_model_inst (.clk, .flashReq, .flashAddr, .flashAck, .flashData,
		.wdByte(wdB), .dcByte(dcB), .swap(bootSwap), .lat);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(logic we, logic [11:0] a, logic [31:0] d, logic [3:0] s, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		cmp("busAck", 32'h1, {31'h0, wb_ack_o});
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
		logic [31:0] q;
		bus(1'b1, a, d, s, q);
	endtask
	task automatic chkReg(string n, logic [11:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		cmp(n, e, q);
	endtask
	// Full power-on style restart, then wait for the fetch to finish
	task automatic boot(logic [7:0] w, logic [7:0] d, logic s, logic [1:0] l);
		int t;
		t = 0;
		wdB <= w;
		dcB <= d;
		bootSwap <= s;
		lat <= l;
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		while (configValid !== 1'b1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		cmp("configValid", 32'h1, {31'h0, configValid});
	endtask
	// The bench never clears the watchdog, so the clear-window rules hold
	task automatic pulse();
		wdtIntervalTick <= 1'b1;
		@(posedge clk);
		wdtIntervalTick <= 1'b0;
		@(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic decode();
		// Images 0D and 6D break the window and level rules on purpose
		logic [15:0] cfg [11] = '{16'hF101, 16'hB333, 16'h4041, 16'h0D63, 16'h5167, 16'h216F,
			16'h616D, 16'h61F3, 16'h6106, 16'h6180, 16'h6101};
		logic [7:0] w, d;
		logic [2:0] e;
		logic bad;
		for (int i = 0; i < 11; i++) begin
			{w, d} = cfg[i];
			boot(w, d, i[0], i[1:0]);
			e = 3'h7;
			if (d[7]) e = 3'h6;
			// Only the combined mode leaves levels undecoded
			else if (d[1:0] != 2'b10) begin
				case ({d[7:5], d[3:2]})
					5'h01: e = 3'h4;
					5'h04: e = 3'h2;
					5'h08: e = 3'h1;
					5'h0C: e = 3'h0;
					5'h0D: e = 3'h3;
					5'h0F: e = 3'h5;
					default: e = 3'h7;
				endcase
			end
			bad = d[1:0] == 2'b00 || e == 3'h7 || (d[1:0] == 2'b01 && e == 3'h5);
			cmp("window", w[0] ? w[6:5] : 2'b11, windowSelect);
			cmp("overflow", w[3:1], overflowTimeSelect);
			cmp("level", e, detectLevel);
			cmp("mode", d[1:0], detectorMode);
			cmp("monitor", !d[4], clockMonitorRun);
			cmp("detRun", e < 3'h6 && !bad, detectorRun);
			cmp("iaDetect", w[4], illegalAccessDetectEnable);
			cmp("cntRun", w[4], wdtCounterRun);
			chkReg("wdReg", 12'h300, {24'h0, w});
			chkReg("dcReg", 12'h304, {24'h0, d});
			chkReg("status", 12'h310, {29'h0, bad, w[6:5] == 2'b00, 1'b1});
			lowPowerMode <= 1'b1;
			repeat (2) @(posedge clk);
			cmp("cntRunLow", w[4] && w[0], wdtCounterRun);
			lowPowerMode <= 1'b0;
		end
		$display("test decode done");
	endtask
	task automatic regs();
		boot(8'h40, 8'h41, 1'b1, 2'h3);
		wr(12'h300, 32'hBF, 4'hF);
		chkReg("wdReg", 12'h300, 32'h40);
		cmp("window", 2'b11, windowSelect);
		chkReg("unmapped", 12'h400, 32'h0);
		wr(12'h318, 32'h1, 4'h0);
		chkReg("ctrlNoSel", 12'h318, 32'h0);
		wr(12'h318, 32'h1, 4'hF);
		chkReg("ctrl", 12'h318, 32'h1);
		cmp("iaDetect", 1'b1, illegalAccessDetectEnable);
		chkReg("decoded", 12'h31C, 32'h0000_0F27);
		wr(12'h314, 32'hF, 4'hF);
		chkReg("mask", 12'h314, 32'hF);
		cmp("irqUp", 1'b1, irq);
		chkReg("status", 12'h310, 32'h1);
		repeat (2) @(negedge clk);
		cmp("irqClr", 1'b0, irq);
		$display("test regs done");
	endtask
	task automatic irqs();
		boot(8'hF1, 8'h6F, 1'b0, 2'h2);
		wr(12'h314, 32'h8, 4'hF);
		pulse();
		cmp("req", 1'b1, intervalIrqReq);
		cmp("flag", 1'b1, intervalIrqFlag);
		repeat (2) @(negedge clk);
		cmp("irqTick", 1'b1, irq);
		wr(12'h314, 32'h0, 4'hF);
		repeat (2) @(negedge clk);
		cmp("irqMasked", 1'b0, irq);
		chkReg("status", 12'h310, 32'h9);
		clkEn <= 1'b0;
		pulse();
		cmp("reqFrozen", 1'b0, intervalIrqReq);
		@(posedge clk);
		clkEn <= 1'b1;
		chkReg("statusFrozen", 12'h310, 32'h0);
		boot(8'h61, 8'h6F, 1'b0, 2'h0);
		pulse();
		cmp("reqOff", 1'b0, intervalIrqReq);
		cmp("flagOff", 1'b0, intervalIrqFlag);
		$display("test irqs done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		results();
	end
	initial begin
		decode();
		regs();
		irqs();
		results();
	end
endmodule
